// ---- verilog/wdgt_top.sv ----
// Windowed watchdog timer: control word, free-running countdown,
// reset generation on expiry, software trigger and halt.
// Assumes the CPU drives the register port on the same clock and that
// the system reset reaches reset when the reset pin is pulled low.
`default_nettype none

// Behaviour
// - Countdown steps down by one every 16000 machine cycles.
// - Active watchdog resets when countdown goes 40h to 3Fh.
// - Watchdog reset holds the reset pin low about 30 us.
// - Countdown keeps running even while watchdog is inactive.
// - Low six countdown bits set one of 64 timeout lengths.
// - Disabled after reset; once active, stays active until reset.
// - Write with activation set and top bit clear resets at once.
// - Halt while active resets unless halt-without-reset is chosen.
// - Hardware option makes watchdog always active, ignoring activation bit.
// - Timeout spread of one step from unknown prescaler phase.
// - Control word resets to 7Fh, activation clear, count all ones.
module wdgt_top
	import wdgt_pkg::*;
#(
	parameter int PRESCALE  = WDGT_PRESCALE_CYC,
	parameter int PULSE_LEN = WDGT_RST_PULSE_CYC
) (
	input  wire logic       clock,       // 200 MHz machine clock
	input  wire logic       reset,       // Sync reset, active high
	input  wire logic [7:0] addr,        // Register address
	input  wire logic [7:0] wdata,       // Write data
	input  wire logic       wr,          // Write strobe
	input  wire logic       rd,          // Read strobe
	output logic      [7:0] rdata,       // Read data, cycle after rd
	input  wire logic       halt_exec,   // Halt instruction executed
	input  wire logic       hw_watchdog, // Option: always active
	input  wire logic       halt_without_reset_option, // Option: halt no reset
	output logic            reset_pin_n, // Reset pin, active low
	output logic            wdg_reset    // Reset request pulse
);

	// ****************************************************************
	// Option capture
	// ****************************************************************
	logic hw_opt_r;
	logic hnr_opt_r;

	// Not reset: option levels are static and must hold through reset,
	// else a halt on the first cycle after reset would miss the option
	always_ff @(posedge clock) begin
		hw_opt_r  <= hw_watchdog;
		hnr_opt_r <= halt_without_reset_option;
	end

	// ****************************************************************
	// Control word
	// ****************************************************************
	logic       activation_bit_r;
	logic [6:0] count_r;
	logic       step;
	logic       ctrl_wr;
	logic       active;
	logic       expire;
	logic       sw_reset;
	logic       halt_reset;
	logic       trigger;
	logic       busy;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] offs);
		hit = (a == offs);
	endfunction : hit

	assign ctrl_wr = wr && hit(addr, WDGT_CTRL_OFFS);
	assign active  = activation_bit_r || hw_opt_r;

	wdgt_prescaler #(
		.DIV (PRESCALE)
	) u_pre (
		.clock (clock),
		.reset (reset),
		.tick  (step)
	);

	// Set only by software; clears only through reset
	always_ff @(posedge clock) begin
		if (reset) begin
			activation_bit_r <= WDGT_CTRL_RESET[WDGT_ACT_BIT];
		end else if (ctrl_wr && wdata[WDGT_ACT_BIT]) begin
			activation_bit_r <= 1'b1;
		end
	end

	// Write wins over a coincident step so a refresh is never lost
	always_ff @(posedge clock) begin
		if (reset) begin
			count_r <= WDGT_CTRL_RESET[6:0];
		end else if (ctrl_wr) begin
			count_r <= wdata[6:0];
		end else if (step) begin
			count_r <= count_r - 7'h01;
		end
	end

	// ****************************************************************
	// Reset sources
	// ****************************************************************
	assign expire = active && step && !ctrl_wr
		&& (count_r == WDGT_EXPIRE_CNT);
	assign sw_reset = ctrl_wr && wdata[WDGT_TOP_BIT] == 1'b0
		&& (wdata[WDGT_ACT_BIT] || active);
	assign halt_reset = halt_exec && active && !hnr_opt_r;
	assign trigger = (expire || sw_reset || halt_reset) && !busy;

	always_ff @(posedge clock) begin
		if (reset) begin
			wdg_reset <= 1'b0;
		end else begin
			wdg_reset <= trigger;
		end
	end

	wdgt_reset_pulse #(
		.LEN (PULSE_LEN)
	) u_pulse (
		.clock       (clock),
		.reset       (reset),
		.trigger     (trigger),
		.reset_pin_n (reset_pin_n),
		.busy        (busy)
	);

	// ****************************************************************
	// Read port
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (reset) begin
			rdata <= 8'h00;
		end else if (rd) begin
			if (hit(addr, WDGT_CTRL_OFFS)) begin
				rdata <= {activation_bit_r, count_r};
			end else if (hit(addr, WDGT_STAT_OFFS)) begin
				rdata <= {6'h00, busy, active};
			end else if (hit(addr, WDGT_OPT_OFFS)) begin
				rdata <= {6'h00, hnr_opt_r, hw_opt_r};
			end else begin
				rdata <= 8'h00;
			end
		end else begin
			rdata <= 8'h00;
		end
	end

endmodule : wdgt_top
`default_nettype wire

// ---- verilog/wdgt_pkg.sv ----
// Package of constants for the windowed watchdog timer.
// Assumes one 200 MHz machine clock shared by all watchdog files.
`default_nettype none
package wdgt_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] WDGT_CTRL_OFFS  = 8'h00;
	localparam logic [7:0] WDGT_STAT_OFFS  = 8'h01;
	localparam logic [7:0] WDGT_OPT_OFFS   = 8'h02;
	localparam logic [7:0] WDGT_CTRL_RESET = 8'h7F;
	localparam logic [6:0] WDGT_EXPIRE_CNT = 7'h40;
	localparam int         WDGT_ACT_BIT    = 7;
	localparam int         WDGT_TOP_BIT    = 6;
	localparam int         WDGT_HWWD_BIT   = 0;
	localparam int         WDGT_HNR_BIT    = 1;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int WDGT_PRESCALE_CYC = 16000;
	localparam int WDGT_CLK_MHZ      = 200;
	localparam int WDGT_RST_PULSE_NS = 30000;
	localparam int WDGT_RST_PULSE_CYC = (WDGT_RST_PULSE_NS * WDGT_CLK_MHZ) / 1000;

	typedef enum logic [1:0] {
		WDGT_IDLE,
		WDGT_PULSE
	} wdgt_rst_state_t;

endpackage : wdgt_pkg
`default_nettype wire

// ---- verilog/wdgt_prescaler.sv ----
// Prescaler: one tick every DIV machine cycles.
// Assumes synchronous active-high reset on the same clock.
`default_nettype none
module wdgt_prescaler
	import wdgt_pkg::*;
#(
	parameter int DIV = WDGT_PRESCALE_CYC
) (
	input  wire logic clock, // Machine clock
	input  wire logic reset, // Sync reset
	output logic      tick   // One-cycle step pulse
);
	logic [15:0] cnt_r;

	// Free running, never restarted by writes
	always_ff @(posedge clock) begin
		if (reset) begin
			cnt_r <= 16'h0000;
		end else if (cnt_r == 16'(DIV - 1)) begin
			cnt_r <= 16'h0000;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end

	assign tick = (cnt_r == 16'(DIV - 1));
endmodule : wdgt_prescaler
`default_nettype wire

// ---- verilog/wdgt_reset_pulse.sv ----
// Reset pulse stretcher: holds the reset pin low for a fixed count.
// Assumes trigger is a one-cycle pulse on the machine clock.
`default_nettype none
module wdgt_reset_pulse
	import wdgt_pkg::*;
#(
	parameter int LEN = WDGT_RST_PULSE_CYC
) (
	input  wire logic clock,       // Machine clock
	input  wire logic reset,       // Sync reset
	input  wire logic trigger,     // Start pulse
	output logic      reset_pin_n, // Reset pin, active low
	output logic      busy         // Pulse in progress
);
	wdgt_rst_state_t state_r;
	logic [15:0]     cnt_r;

	always_ff @(posedge clock) begin
		if (reset) begin
			state_r <= WDGT_IDLE;
			cnt_r   <= 16'h0000;
		end else begin
			case (state_r)
				WDGT_IDLE: begin
					if (trigger) begin
						state_r <= WDGT_PULSE;
						cnt_r   <= 16'(LEN - 1);
					end
				end
				WDGT_PULSE: begin
					if (cnt_r == 16'h0000) begin
						state_r <= WDGT_IDLE;
					end else begin
						cnt_r <= cnt_r - 16'h0001;
					end
				end
				default: begin
					state_r <= WDGT_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			reset_pin_n <= 1'b1;
		end else begin
			reset_pin_n <= !(state_r == WDGT_PULSE && cnt_r != 16'h0000) && !trigger;
		end
	end

	assign busy = (state_r == WDGT_PULSE);
endmodule : wdgt_reset_pulse
`default_nettype wire

// ---- test/wdgt_properties.sv ----
// Port-level properties of the watchdog top.
// Assumes one clock and the bench's short prescale and pulse counts.
`default_nettype none
module wdgt_properties #(
	parameter int PRESCALE  = 8,
	parameter int PULSE_LEN = 4
) (
	input wire logic       clock,                     // Clock
	input wire logic       reset,                     // Sync reset
	input wire logic [7:0] addr,                      // Address
	input wire logic [7:0] wdata,                     // Write data
	input wire logic       wr,                        // Write strobe
	input wire logic       rd,                        // Read strobe
	input wire logic [7:0] rdata,                     // Read data
	input wire logic       halt_exec,                 // Halt pulse
	input wire logic       hw_watchdog,               // Option
	input wire logic       halt_without_reset_option, // Option
	input wire logic       reset_pin_n,               // Reset pin
	input wire logic       wdg_reset                  // Reset request
);
	logic [15:0] low_cnt_r;
	logic        seen_act_r;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	always_ff @(posedge clock) begin
		low_cnt_r <= reset_pin_n ? 16'h0000 : low_cnt_r + 16'h0001;
	end
	// Once status showed active, only a reset may clear it
	always_ff @(posedge clock) begin
		if (reset)
			seen_act_r <= 1'b0;
		else if ($past(rd) && $past(addr) == 8'h01 && rdata[0])
			seen_act_r <= 1'b1;
	end
	sequence s_wr_ctrl;
		wr && addr == 8'h00 && wdata[7:6] == 2'b11;
	endsequence
	sequence s_rd_ctrl;
		rd && addr == 8'h00;
	endsequence
	property p_wr_rd;
		s_wr_ctrl ##1 s_rd_ctrl |=> rdata == $past(wdata, 2);
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("ctrl readback wrong");
	property p_sw_rst;
		wr && addr == 8'h00 && wdata[7:6] == 2'b10 && reset_pin_n && !wdg_reset |=> wdg_reset;
	endproperty
	a_sw_rst: assert property (p_sw_rst) else $error("no software reset");
	property p_pin;
		wdg_reset |-> $fell(reset_pin_n);
	endproperty
	a_pin: assert property (p_pin) else $error("pin not pulled with request");
	property p_once;
		wdg_reset |=> !wdg_reset && !reset_pin_n;
	endproperty
	a_once: assert property (p_once) else $error("request or pin shape wrong");
	property p_len;
		$rose(reset_pin_n) |-> low_cnt_r == PULSE_LEN;
	endproperty
	a_len: assert property (p_len) else $error("pin low length wrong");
	property p_halt;
		halt_exec && hw_watchdog && $past(hw_watchdog) && !halt_without_reset_option
			&& !$past(halt_without_reset_option) && reset_pin_n && !wdg_reset |=> wdg_reset;
	endproperty
	a_halt: assert property (p_halt) else $error("halt gave no reset");
	property p_hw_act;
		rd && addr == 8'h01 && hw_watchdog && $past(hw_watchdog) |=> rdata[0];
	endproperty
	a_hw_act: assert property (p_hw_act) else $error("hw option not active");
	property p_sticky;
		seen_act_r && $past(rd) && $past(addr) == 8'h01 |-> rdata[0];
	endproperty
	a_sticky: assert property (p_sticky) else $error("activation cleared");
endmodule : wdgt_properties
bind wdgt_top wdgt_properties #(.PRESCALE(PRESCALE), .PULSE_LEN(PULSE_LEN)) wdgt_properties_i (
	.clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .halt_exec(halt_exec), .hw_watchdog(hw_watchdog),
	.halt_without_reset_option(halt_without_reset_option),
	.reset_pin_n(reset_pin_n), .wdg_reset(wdg_reset));
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the watchdog top through its register port.
// Assumes the bench itself applies system reset after each reset pulse.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clock = 1'b0;
	logic       reset = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       halt_exec = 1'b0;
	logic       hw_watchdog = 1'b0;
	logic       halt_without_reset_option = 1'b0;
	logic [7:0] rdata;
	logic       reset_pin_n;
	logic       wdg_reset;
	int         err_count = 0;
	int         n_checks = 0;
	int         cyc = 0;
	int         n;
	always #2.5 clock = ~clock;
	wdgt_top #(.PRESCALE(8), .PULSE_LEN(4)) wdgt_top_i (.clock(clock), .reset(reset),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .halt_exec(halt_exec),
		.hw_watchdog(hw_watchdog), .halt_without_reset_option(halt_without_reset_option),
		.reset_pin_n(reset_pin_n), .wdg_reset(wdg_reset));
	task automatic chk(input string s, input logic [7:0] lo, hi, got);
		n_checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			err_count++;
			$display("[FAIL] %s expected %h..%h seen %h", s, lo, hi, got);
		end
	endtask : chk
	task automatic finish_test;
		if (err_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test
	task automatic sys_rst(input int nc);
		@(posedge clock);
		reset <= 1'b1;
		repeat (nc) @(posedge clock);
		reset <= 1'b0;
	endtask : sys_rst
	task automatic wr_reg(input logic [7:0] a, d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rdc(input string s, input logic [7:0] a, lo, hi);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		chk(s, lo, hi, rdata);
	endtask : rdc
	// Read straight after the write, so no step can slip between
	task automatic wrrd(input string s, input logic [7:0] d);
		wr_reg(8'h00, d);
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		chk(s, d, d, rdata);
	endtask : wrrd
	task automatic halt;
		@(posedge clock);
		halt_exec <= 1'b1;
		@(posedge clock);
		halt_exec <= 1'b0;
	endtask : halt
	task automatic wait_rst(input int max);
		n = 0;
		#1;
		while (wdg_reset !== 1'b1 && n < max) begin
			@(posedge clock);
			#1;
			n++;
		end
	endtask : wait_rst
	task automatic exp_rst(input string s, input logic [7:0] lo, hi);
		wait_rst(40);
		chk(s, lo, hi, 8'(n));
		chk("pin_low", 8'h00, 8'h00, {7'h00, reset_pin_n});
		repeat (3) @(posedge clock);
		#1;
		chk("pin_held", 8'h00, 8'h00, {7'h00, reset_pin_n});
		repeat (3) @(posedge clock);
		#1;
		chk("pin_end", 8'h01, 8'h01, {7'h00, reset_pin_n});
		sys_rst(2);
	endtask : exp_rst
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			finish_test;
		end
	end
	initial begin
		sys_rst(20);
		rdc("ctrl", 8'h00, 8'h7F, 8'h7F);
		rdc("status", 8'h01, 8'h00, 8'h00);
		wr_reg(8'h05, 8'h12);
		rdc("unmapped", 8'h05, 8'h00, 8'h00);
		wrrd("load", 8'h43);
		wait_rst(40);
		chk("inactive", 8'h28, 8'h28, 8'(n));
		rdc("count", 8'h00, 8'h3D, 8'h3E);
		wrrd("arm", 8'hC7);
		rdc("active", 8'h01, 8'h01, 8'h01);
		wr_reg(8'h00, 8'h7F);
		rdc("keep", 8'h00, 8'hFE, 8'hFF);
		rdc("still", 8'h01, 8'h01, 8'h01);
		for (int k = 1; k <= 3; k += 2) begin
			wrrd("arm_k", 8'hC0 + 8'(k));
			exp_rst("expiry", 8'(8 * k - 2), 8'(8 * k + 7));
		end
		rdc("ctrl_again", 8'h00, 8'h7F, 8'h7F);
		rdc("off_again", 8'h01, 8'h00, 8'h00);
		for (int k = 0; k < 2; k++) begin
			wr_reg(8'h00, k ? 8'hBF : 8'h80);
			exp_rst("sw", 8'h00, 8'h00);
		end
		halt_without_reset_option <= 1'b1;
		wrrd("arm_h", 8'hFF);
		halt;
		wait_rst(10);
		chk("halt_kept", 8'h0A, 8'h0A, 8'(n));
		@(posedge clock);
		halt_without_reset_option <= 1'b0;
		halt;
		exp_rst("halt", 8'h00, 8'h00);
		hw_watchdog <= 1'b1;
		rdc("hw_act", 8'h01, 8'h01, 8'h01);
		rdc("opts", 8'h02, 8'h01, 8'h01);
		wr_reg(8'h00, 8'h41);
		exp_rst("hw_exp", 8'h07, 8'h11);
		halt;
		exp_rst("hw_halt", 8'h00, 8'h00);
		finish_test;
	end
endmodule : testbench
`default_nettype wire
